//--- logic/ecp_svc_pkg.sv
// package: constants, types and register map of the fifo service-request block
package ecp_svc_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses on the wishbone bus)
    // ------------------------------------------------------------
    localparam logic [10:0] CMDQ_OFS = 11'h000;
    localparam logic [10:0] DATAQ_OFS = 11'h400;
    localparam logic [10:0] CTRL_OFS = 11'h408;
    localparam logic [10:0] STAT_OFS = 11'h40c;

    // status word field positions
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_EMPTY_BIT = 5;
    localparam int STAT_FULL_BIT = 6;
    localparam int STAT_REQ_BIT = 7;
    localparam int STAT_HOLD_BIT = 8;
    localparam int STAT_IRQ_BIT = 9;

    // ------------------------------------------------------------
    // queue geometry and thresholds
    // ------------------------------------------------------------
    localparam int DEPTH = 16;
    localparam logic [4:0] DEPTH_CNT = 5'h10;
    localparam logic [4:0] THR_CAP = 5'h0f;
    localparam logic [5:0] BURST_MAX = 6'h20;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int HOLD_NS = 350;
    localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_PULSE_NS = 100;
    localparam int IRQ_PULSE_CYC = (IRQ_PULSE_NS * CLK_MHZ) / 1000;

    // pin synchroniser reset image: ack_n and ior_n idle high
    localparam logic [10:0] PIN_SYNC_RST = 11'h600;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_DATA = 2'h0,
        MODE_COMPAT = 2'h1,
        MODE_TEST = 2'h2
    } queue_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REQ = 3'b010,
        ST_HOLD = 3'b100
    } dma_state_t;

    typedef struct packed {
        logic [3:0] trigger_setting;
        logic service_mask;
        logic dma_request_allow;
        queue_mode_t mode;
        logic direction;
    } ctrl_t;

    typedef struct packed {
        logic cmd;
        logic [7:0] data;
    } entry_t;

    localparam ctrl_t CTRL_RST = '{trigger_setting: 4'h0, service_mask: 1'b1,
        dma_request_allow: 1'b0, mode: MODE_DATA, direction: 1'b0};
    localparam entry_t ENTRY_RST = '{cmd: 1'b0, data: 8'h00};

endpackage

//--- logic/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    // ------------------------------------------------------------
    // one two-stage chain per bit
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_ff;
            logic sync_ff;
            // first stage is read only by the second
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta_ff <= RST_VAL[i];
                    sync_ff <= RST_VAL[i];
                end else if (ce) begin
                    meta_ff <= d[i];
                    sync_ff <= meta_ff;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate

endmodule

//--- logic/ecp_svc_req.sv
// fifo service-request logic: dma request, burst limit, pio interrupts
//
// Our own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// - dma moves only data, test or compat bytes, never command bytes
// - terminal count raises an interrupt and sets service_mask
// - request at most 32 cycles in a row, then low until ack high 350 ns
// - during dma the queue is selected by the ack alone
// - reverse dma: request while data held, drop on empty or qualified tc
// - last byte: request drops on ack, else on read strobe edge
// - re-request on one byte; after tc also needs mask cleared
// - pio data/test queue at 400h, command queue write-only at 000h
// - threshold 16 acts as threshold 15
// - reverse pio interrupts when count >= 16 minus threshold
// - forward pio interrupts when count <= threshold
// - threshold is trigger_setting plus one, range 1 to 16
// - each interrupt is a brief low pulse, then the line floats
module ecp_svc_req import ecp_svc_pkg::*; (
    // clock, reset, enable
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic CE,
    // wishbone slave
    input wire logic [10:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    // isa dma pins
    input wire logic PORT_DMA_ACK_N,
    input wire logic PORT_DMA_TC,
    input wire logic PORT_IOR_N,
    input wire logic [7:0] PORT_DMA_WDATA,
    output logic [7:0] PORT_DMA_RDATA,
    output logic PORT_DMA_REQUEST,
    // shared interrupt pin
    output logic PORT_IRQ_PIN_O,
    output logic PORT_IRQ_PIN_OE,
    // peripheral side, reverse fill
    input wire logic PER_IN_VALID,
    input wire logic [7:0] PER_IN_DATA,
    output logic PER_IN_READY,
    // peripheral side, forward drain
    output logic PER_OUT_VALID,
    output logic [7:0] PER_OUT_DATA,
    output logic PER_OUT_CMD,
    input wire logic PER_OUT_TAKEN
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [10:0] pin_q;
    logic ack_n_s;
    logic tc_s;
    logic ior_n_s;
    logic [7:0] wdata_s;
    logic ack_n_d_ff;
    logic ior_n_d_ff;
    logic ack_fall;
    logic ior_fall;
    logic tc_evt;

    pin_sync #(.WIDTH(11), .RST_VAL(PIN_SYNC_RST)) u_pin_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .ce(CE),
        .d({PORT_DMA_ACK_N, PORT_IOR_N, PORT_DMA_TC, PORT_DMA_WDATA}),
        .q(pin_q)
    );

    assign ack_n_s = pin_q[10];
    assign ior_n_s = pin_q[9];
    assign tc_s = pin_q[8];
    assign wdata_s = pin_q[7:0];

    // edge history of synchronised strobes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_n_d_ff <= 1'b1;
            ior_n_d_ff <= 1'b1;
        end else if (CE) begin
            ack_n_d_ff <= ack_n_s;
            ior_n_d_ff <= ior_n_s;
        end
    end

    // a dma cycle starts on the falling ack, queue chosen by ack alone
    assign ack_fall = ack_n_d_ff & ~ack_n_s;
    assign ior_fall = ior_n_d_ff & ~ior_n_s;
    // terminal count only counts when qualified by the ack
    assign tc_evt = ack_fall & tc_s;

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    ctrl_t ctrl_ff, nxt_ctrl;
    logic ack_ff, nxt_ack;
    logic [31:0] dat_ff, nxt_dat;
    logic wb_push, wb_pop;
    entry_t wb_entry;

    entry_t mem_ff [DEPTH];
    entry_t nxt_mem [DEPTH];
    logic [3:0] wr_ptr_ff, nxt_wr_ptr;
    logic [3:0] rd_ptr_ff, nxt_rd_ptr;
    logic [4:0] count_ff, nxt_count;
    logic push, pop;
    entry_t push_entry;
    entry_t head;
    logic empty, full;
    logic in_ready_ff, nxt_in_ready;
    logic out_valid_ff, nxt_out_valid;
    entry_t out_ff, nxt_out;
    logic out_load, per_push, dma_push, dma_pop;

    dma_state_t state_ff, nxt_state;
    logic [5:0] burst_ff, nxt_burst;
    logic [5:0] hold_ff, nxt_hold;
    logic req_ff, nxt_req;
    logic [7:0] rdata_ff, nxt_rdata;
    logic want;

    logic cond_ff, nxt_cond;
    logic [5:0] pulse_ff, nxt_pulse;
    logic irq_oe_ff, nxt_irq_oe;
    logic irq_o_ff;
    logic [4:0] thr;
    logic cond;
    logic irq_evt;

    logic fwd, test_mode, qsel;

    assign fwd = ~ctrl_ff.direction;
    assign test_mode = (ctrl_ff.mode == MODE_TEST);
    assign head = mem_ff[rd_ptr_ff];
    assign empty = (count_ff == 5'h00);
    assign full = (count_ff == DEPTH_CNT);
    assign qsel = (WB_ADR_I == DATAQ_OFS) || (WB_ADR_I == CMDQ_OFS);

    // ------------------------------------------------------------
    // wishbone register slave
    // ------------------------------------------------------------
    // one access per ack; queue access waits out a dma cycle edge
    always_comb begin
        logic take;
        logic [31:0] word;
        logic [31:0] stat;
        take = WB_CYC_I & WB_STB_I & ~ack_ff & ~(qsel & ack_fall);
        word = {23'h000000, ctrl_ff};
        stat = 32'h00000000;
        stat[STAT_CNT_LSB +: 5] = count_ff;
        stat[STAT_EMPTY_BIT] = empty;
        stat[STAT_FULL_BIT] = full;
        stat[STAT_REQ_BIT] = req_ff;
        stat[STAT_HOLD_BIT] = (state_ff == ST_HOLD);
        stat[STAT_IRQ_BIT] = irq_oe_ff;
        nxt_ctrl = ctrl_ff;
        nxt_ack = 1'b0;
        nxt_dat = dat_ff;
        wb_push = 1'b0;
        wb_pop = 1'b0;
        wb_entry = ENTRY_RST;
        if (take) begin
            nxt_ack = 1'b1;
            nxt_dat = 32'h00000000;
            if (WB_ADR_I == CTRL_OFS) begin
                if (WB_WE_I) begin
                    if (WB_SEL_I[0]) begin
                        word[7:0] = WB_DAT_I[7:0];
                    end
                    if (WB_SEL_I[1]) begin
                        word[8] = WB_DAT_I[8];
                    end
                    nxt_ctrl = ctrl_t'(word[8:0]);
                end else begin
                    nxt_dat = word;
                end
            end else if (WB_ADR_I == STAT_OFS) begin
                nxt_dat = stat;
            end else if (WB_ADR_I == DATAQ_OFS) begin
                // data or test queue at 400h
                if (WB_WE_I && WB_SEL_I[0] && (fwd || test_mode)) begin
                    wb_push = 1'b1;
                    wb_entry = '{cmd: 1'b0, data: WB_DAT_I[7:0]};
                end else if (!WB_WE_I && (!fwd || test_mode) && !empty) begin
                    wb_pop = 1'b1;
                    nxt_dat = {24'h000000, head.data};
                end
            end else if (WB_ADR_I == CMDQ_OFS) begin
                // command queue is write-only, reads return zero
                if (WB_WE_I && WB_SEL_I[0] && fwd && !test_mode) begin
                    wb_push = 1'b1;
                    wb_entry = '{cmd: 1'b1, data: WB_DAT_I[7:0]};
                end
            end
        end
        // terminal count masks further service, winning over a write
        if (tc_evt && ctrl_ff.dma_request_allow) begin
            nxt_ctrl.service_mask = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_ff <= CTRL_RST;
            ack_ff <= 1'b0;
            dat_ff <= 32'h00000000;
        end else if (CE) begin
            ctrl_ff <= nxt_ctrl;
            ack_ff <= nxt_ack;
            dat_ff <= nxt_dat;
        end
    end

    // ------------------------------------------------------------
    // byte queue with output stage
    // ------------------------------------------------------------
    assign dma_push = ack_fall & fwd & ~full;
    assign dma_pop = ack_fall & ~fwd & ~empty;
    assign per_push = PER_IN_VALID & in_ready_ff;
    assign out_load = fwd & ~test_mode & ~empty & (~out_valid_ff | PER_OUT_TAKEN);

    // one push and one pop per cycle, sources exclusive by direction
    always_comb begin
        nxt_mem = mem_ff;
        push = 1'b0;
        pop = 1'b0;
        // dma bytes always enter as data, never as commands
        push_entry = '{cmd: 1'b0, data: wdata_s};
        if (dma_push) begin
            push = 1'b1;
        end else if (wb_push && !full) begin
            push = 1'b1;
            push_entry = wb_entry;
        end else if (per_push && !full) begin
            push = 1'b1;
            push_entry = '{cmd: 1'b0, data: PER_IN_DATA};
        end
        pop = dma_pop | wb_pop | out_load;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_rd_ptr = rd_ptr_ff;
        if (push) begin
            nxt_mem[wr_ptr_ff] = push_entry;
            nxt_wr_ptr = wr_ptr_ff + 4'h1;
        end
        if (pop) begin
            nxt_rd_ptr = rd_ptr_ff + 4'h1;
        end
        nxt_count = count_ff + {4'h0, push} - {4'h0, pop};
        nxt_in_ready = ctrl_ff.direction & ~test_mode & (nxt_count != DEPTH_CNT);
        nxt_out_valid = out_valid_ff & ~PER_OUT_TAKEN;
        nxt_out = out_ff;
        if (out_load) begin
            nxt_out_valid = 1'b1;
            nxt_out = head;
        end
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= ENTRY_RST;
            end
            wr_ptr_ff <= 4'h0;
            rd_ptr_ff <= 4'h0;
            count_ff <= 5'h00;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_ff <= ENTRY_RST;
        end else if (CE) begin
            mem_ff <= nxt_mem;
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            count_ff <= nxt_count;
            in_ready_ff <= nxt_in_ready;
            out_valid_ff <= nxt_out_valid;
            out_ff <= nxt_out;
        end
    end

    // ------------------------------------------------------------
    // dma request state machine
    // ------------------------------------------------------------
    // request wanted on the post-transfer count, so the last byte drops it
    assign want = nxt_ctrl.dma_request_allow & ~nxt_ctrl.service_mask &
        (ctrl_ff.direction ? (nxt_count != 5'h00) : (nxt_count != DEPTH_CNT));

    always_comb begin
        nxt_state = state_ff;
        nxt_burst = burst_ff;
        nxt_hold = hold_ff;
        // read data is presented while the ack is still high
        nxt_rdata = ack_n_s ? head.data : rdata_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_burst = 6'h00;
                if (want) begin
                    nxt_state = ST_REQ;
                end
            end
            ST_REQ: begin
                if (ack_fall) begin
                    nxt_burst = burst_ff + 6'h01;
                end
                if (ack_fall && nxt_burst == BURST_MAX) begin
                    // burst limit reached: hold off the request
                    nxt_state = ST_HOLD;
                    nxt_hold = 6'h00;
                end else if (!want) begin
                    nxt_state = ST_IDLE;
                end else if (ior_fall && ctrl_ff.direction && count_ff == 5'h01) begin
                    // last byte read without an ack edge
                    nxt_state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // ack must stay high for the full hold time
                if (ack_n_s) begin
                    nxt_hold = hold_ff + 6'h01;
                end else begin
                    nxt_hold = 6'h00;
                end
                if (nxt_hold == 6'(HOLD_CYC)) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        nxt_req = (nxt_state == ST_REQ);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_ff <= ST_IDLE;
            burst_ff <= 6'h00;
            hold_ff <= 6'h00;
            req_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else if (CE) begin
            state_ff <= nxt_state;
            burst_ff <= nxt_burst;
            hold_ff <= nxt_hold;
            req_ff <= nxt_req;
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------
    // service interrupt
    // ------------------------------------------------------------
    // threshold is setting plus one, sixteen folded onto fifteen
    always_comb begin
        thr = {1'b0, ctrl_ff.trigger_setting} + 5'h01;
        if (thr == DEPTH_CNT) begin
            thr = THR_CAP;
        end
    end

    // pio level condition; a rise or a mask release fires a pulse
    always_comb begin
        cond = 1'b0;
        if (!ctrl_ff.service_mask && !ctrl_ff.dma_request_allow) begin
            if (ctrl_ff.direction) begin
                cond = (count_ff >= (DEPTH_CNT - thr));
            end else begin
                cond = (count_ff <= thr);
            end
        end
        nxt_cond = cond;
        irq_evt = (cond & ~cond_ff) |
            (tc_evt & ctrl_ff.dma_request_allow & ~ctrl_ff.service_mask);
        nxt_pulse = pulse_ff;
        if (irq_evt) begin
            nxt_pulse = 6'(IRQ_PULSE_CYC);
        end else if (pulse_ff != 6'h00) begin
            nxt_pulse = pulse_ff - 6'h01;
        end
        // drive low only while the pulse runs, float otherwise
        nxt_irq_oe = (nxt_pulse != 6'h00);
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cond_ff <= 1'b0;
            pulse_ff <= 6'h00;
            irq_oe_ff <= 1'b0;
            irq_o_ff <= 1'b0;
        end else if (CE) begin
            cond_ff <= nxt_cond;
            pulse_ff <= nxt_pulse;
            irq_oe_ff <= nxt_irq_oe;
            irq_o_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign WB_DAT_O = dat_ff;
    assign WB_ACK_O = ack_ff;
    assign PORT_DMA_RDATA = rdata_ff;
    assign PORT_DMA_REQUEST = req_ff;
    assign PORT_IRQ_PIN_O = irq_o_ff;
    assign PORT_IRQ_PIN_OE = irq_oe_ff;
    assign PER_IN_READY = in_ready_ff;
    assign PER_OUT_VALID = out_valid_ff;
    assign PER_OUT_DATA = out_ff.data;
    assign PER_OUT_CMD = out_ff.cmd;

endmodule

//--- testbench/ecp_svc_req_checker.sv
// checker: port timing relations of the fifo service-request block
`timescale 1ns/1ps
module ecp_svc_req_checker (
    // clock and reset
    input wire logic CLK,
    input wire logic ARST_N,
    // wishbone handshake
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    // dma and interrupt pins
    input wire logic PORT_DMA_ACK_N,
    input wire logic PORT_DMA_TC,
    input wire logic PORT_DMA_REQUEST,
    input wire logic PORT_IRQ_PIN_O,
    input wire logic PORT_IRQ_PIN_OE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    logic ack_ff, req_ff, hold_ff, nxt_hold;
    logic [5:0] burst_ff, nxt_burst, high_ff, nxt_high;
    // burst count, ack-high run, hold-off flag
    always_comb begin
        nxt_burst = burst_ff + {5'h00, ack_ff & ~PORT_DMA_ACK_N};
        if (!PORT_DMA_REQUEST) begin
            nxt_burst = 6'h00;
        end
        nxt_high = (high_ff == 6'h3f) ? high_ff : high_ff + 6'h01;
        if (!PORT_DMA_ACK_N) begin
            nxt_high = 6'h00;
        end
        nxt_hold = hold_ff;
        if (req_ff && !PORT_DMA_REQUEST) begin
            nxt_hold = (burst_ff == 6'h20);
        end
    end
    // helper registers
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_ff <= 1'b1;
            req_ff <= 1'b0;
            hold_ff <= 1'b0;
            burst_ff <= 6'h00;
            high_ff <= 6'h00;
        end else begin
            ack_ff <= PORT_DMA_ACK_N;
            req_ff <= PORT_DMA_REQUEST;
            hold_ff <= nxt_hold;
            burst_ff <= nxt_burst;
            high_ff <= nxt_high;
        end
    end
    sequence tc_taken;
        $fell(PORT_DMA_ACK_N) && PORT_DMA_TC && PORT_DMA_REQUEST;
    endsequence
    a_irq_drives_low: assert property (PORT_IRQ_PIN_O == 1'b0)
        else $error("irq pin driven high");
    a_irq_pulse_len: assert property ($rose(PORT_IRQ_PIN_OE) |->
        PORT_IRQ_PIN_OE[*8] ##1 PORT_IRQ_PIN_OE ##1 PORT_IRQ_PIN_OE ##1 !PORT_IRQ_PIN_OE)
        else $error("irq pulse not ten cycles");
    a_wb_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_wb_ack_bound: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |-> ##[1:2] WB_ACK_O)
        else $error("bus access not answered");
    a_wb_ack_cause: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    a_burst_limit: assert property (burst_ff <= 6'h20)
        else $error("more than 32 dma cycles in one request");
    a_hold_gap: assert property ($rose(PORT_DMA_REQUEST) && hold_ff |-> high_ff >= 6'h23)
        else $error("request back too early after burst");
    a_tc_stop: assert property (tc_taken |->
        ##[1:6] !PORT_DMA_REQUEST ##1 !PORT_DMA_REQUEST[*8])
        else $error("request not stopped by terminal count");
    a_tc_irq: assert property (tc_taken |-> ##[1:6] $rose(PORT_IRQ_PIN_OE))
        else $error("no interrupt on terminal count");
    c_req: cover property ($rose(PORT_DMA_REQUEST));
    c_irq: cover property ($rose(PORT_IRQ_PIN_OE));
    c_hold: cover property ($rose(PORT_DMA_REQUEST) && hold_ff);
    c_tc: cover property (tc_taken);
endmodule
bind ecp_svc_req ecp_svc_req_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .PORT_DMA_ACK_N(PORT_DMA_ACK_N),
    .PORT_DMA_TC(PORT_DMA_TC), .PORT_DMA_REQUEST(PORT_DMA_REQUEST),
    .PORT_IRQ_PIN_O(PORT_IRQ_PIN_O), .PORT_IRQ_PIN_OE(PORT_IRQ_PIN_OE));

//--- testbench/isa_dma_host.sv
// host dma controller model: one byte per ack pulse, terminal count on a chosen cycle
`timescale 1ns/1ps
module isa_dma_host (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // control from the bench
    input wire logic en,
    input wire logic [7:0] tc_at,
    output logic [7:0] n_cyc,
    // dma pins
    input wire logic request,
    output logic ack_n,
    output logic tc,
    output logic ior_n,
    output logic [7:0] wdata
);
    logic [2:0] ph;
    // ack low three cycles, high at least four; no address is ever driven
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ph <= 3'h0;
            ack_n <= 1'b1;
            tc <= 1'b0;
            ior_n <= 1'b1;
            wdata <= 8'h00;
            n_cyc <= 8'h00;
        end else if (ph != 3'h0) begin
            ph <= (ph == 3'h6) ? 3'h0 : ph + 3'h1;
            if (ph == 3'h3) begin
                ack_n <= 1'b1;
                ior_n <= 1'b1;
                tc <= 1'b0;
                wdata <= n_cyc;
            end
        end else if (en && request) begin
            // terminal count is driven only on the programmed cycle, numbered tc_at
            ack_n <= 1'b0;
            ior_n <= 1'b0;
            tc <= ((n_cyc + 8'h01) == tc_at);
            n_cyc <= n_cyc + 8'h01;
            ph <= 3'h1;
        end
    end
endmodule

//--- testbench/ecp_svc_req_tb.sv
// testbench: register access, pio interrupts and dma service of the fifo block
`timescale 1ns/1ps
module ecp_svc_req_tb import ecp_svc_pkg::*;;
    logic clk, arst_n, cyc, stb, we, in_v, take, host_en;
    logic ack, in_rdy, dma_ack_n, dma_tc, ior_n, req, irq_o, oe, out_v, out_cmd;
    logic [10:0] adr;
    logic [31:0] wdat, rdat, dout;
    logic [7:0] in_d, tc_at, n_cyc, dma_wd, dma_rd, out_d;
    int n_mismatch, check_count, i;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ecp_svc_req dut (.CLK(clk), .ARST_N(arst_n), .CE(1'b1), .WB_ADR_I(adr), .WB_DAT_I(wdat),
        .WB_SEL_I(4'hf), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(dout),
        .WB_ACK_O(ack), .PORT_DMA_ACK_N(dma_ack_n), .PORT_DMA_TC(dma_tc), .PORT_IOR_N(ior_n),
        .PORT_DMA_WDATA(dma_wd), .PORT_DMA_RDATA(dma_rd), .PORT_DMA_REQUEST(req),
        .PORT_IRQ_PIN_O(irq_o), .PORT_IRQ_PIN_OE(oe), .PER_IN_VALID(in_v), .PER_IN_DATA(in_d),
        .PER_IN_READY(in_rdy), .PER_OUT_VALID(out_v), .PER_OUT_DATA(out_d),
        .PER_OUT_CMD(out_cmd), .PER_OUT_TAKEN(take));
    isa_dma_host host (.clk(clk), .arst_n(arst_n), .en(host_en), .tc_at(tc_at), .n_cyc(n_cyc),
        .request(req), .ack_n(dma_ack_n), .tc(dma_tc), .ior_n(ior_n), .wdata(dma_wd));

    task automatic complete_run;
        if (n_mismatch == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [10:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        k = 0;
        do @(posedge clk); while (ack !== 1'b1 && ++k < 50);
        if (k >= 50) begin
            n_mismatch++;
            complete_run();
        end
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rdat);
    endtask
    task automatic push(input logic [7:0] b);
        int k;
        @(posedge clk);
        in_v <= 1'b1;
        in_d <= b;
        k = 0;
        do @(posedge clk); while (in_rdy !== 1'b1 && ++k < 50);
        chk("peripheral ready", 32'h1, {31'h0, in_rdy});
        in_v <= 1'b0;
    endtask
    task automatic irq(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (20) @(posedge clk) if (oe === 1'b1) seen = 1'b1;
        chk("irq pulse", {31'h0, e}, {31'h0, seen});
    endtask
    task automatic wait_cnt(input logic [4:0] c);
        int k;
        for (k = 0; k < 100; k++) begin
            wb(1'b0, STAT_OFS, 32'h0);
            if (rdat[4:0] === c) break;
        end
        chk("queue count", {27'h0, c}, {27'h0, rdat[4:0]});
    endtask

    initial begin
        n_mismatch = 0;
        check_count = 0;
        arst_n = 1'b0;
        {cyc, stb, we, in_v, take, host_en} = 6'h00;
        adr = 11'h000;
        wdat = 32'h0;
        in_d = 8'h00;
        tc_at = 8'h00;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        // reset image, unmapped and write-only places
        rd(CTRL_OFS, 32'h010);
        rd(STAT_OFS, 32'h020);
        rd(11'h404, 32'h0);
        rd(CMDQ_OFS, 32'h0);
        // forward pio: command byte, then fill-level interrupts
        wr(CMDQ_OFS, 32'ha5);
        i = 0;
        while (out_v !== 1'b1 && i < 20) begin
            @(posedge clk);
            i++;
        end
        chk("command out", 32'h3a5, {22'h0, out_v, out_cmd, out_d});
        wr(CTRL_OFS, 32'h060);
        irq(1'b1);
        for (i = 0; i < 5; i++) wr(DATAQ_OFS, 32'h10 + i);
        irq(1'b0);
        take <= 1'b1;
        irq(1'b1);
        // reverse pio: top setting acts as fifteen
        wr(CTRL_OFS, 32'h1e1);
        irq(1'b0);
        push(8'h3c);
        irq(1'b1);
        rd(DATAQ_OFS, 32'h3c);
        wr(CTRL_OFS, 32'h061);
        for (i = 0; i < 11; i++) push(i[7:0]);
        irq(1'b0);
        push(8'h0b);
        irq(1'b1);
        for (i = 12; i < 16; i++) push(i[7:0]);
        rd(STAT_OFS, 32'h050);
        rd(DATAQ_OFS, 32'h00);
        rd(DATAQ_OFS, 32'h01);
        // reverse dma drains the queue, re-requests on one byte
        host_en <= 1'b1;
        wr(CTRL_OFS, 32'h009);
        wait_cnt(5'h00);
        chk("dma cycles", 32'd14, {24'h0, n_cyc});
        tc_at <= 8'd17;
        push(8'h77);
        repeat (2) @(posedge clk);
        chk("dma byte", 32'h77, {24'h0, dma_rd});
        wait_cnt(5'h00);
        // tc after two bytes leaves two queued
        for (i = 0; i < 4; i++) push(8'h80 + i[7:0]);
        repeat (40) @(posedge clk);
        rd(CTRL_OFS, 32'h019);
        rd(STAT_OFS, 32'h002);
        wr(CTRL_OFS, 32'h009);
        wait_cnt(5'h00);
        chk("dma cycles", 32'd19, {24'h0, n_cyc});
        // forward dma: burst limit and hold-off
        wr(CTRL_OFS, 32'h008);
        repeat (600) @(posedge clk);
        chk("burst resumed", 32'h1, {31'h0, n_cyc > 8'd52});
        host_en <= 1'b0;
        wr(CTRL_OFS, 32'h018);
        wr(CTRL_OFS, 32'h010);
        complete_run();
    end
endmodule
